/* bench/lrc_framer_model.sv */
/*
 Framer-side sink for one receive channel: takes the rails on the
 launch edge and counts rail changes that land away from it.
 Assumes muting is off while the count is being judged.
*/
`timescale 1ns/10ps

module lrc_framer_model (
    input wire logic rclk,
    input wire logic pos,
    input wire logic neg,
    input wire logic edgeSel,
    output int badLaunch,
    output logic [1:0] held
);
    initial begin
        badLaunch = 0;
        held = 2'h0;
    end

    // look 1 ns past each edge so the launch has surely landed
    always @(rclk) begin
        #1;
        if (rclk === !edgeSel) begin
            held = {pos, neg};
        end else if ({pos, neg} !== held) begin
            badLaunch = badLaunch + 1;
        end
    end
endmodule : lrc_framer_model

/* bench/tb_top.sv */
/*
 Self-checking bench for lrc_top: register map, loss logic, muting
 and launch edge. Assumes the framer model beside it; all twelve
 recovered clocks come from one free-running 12 ns link clock.
*/
`timescale 1ns/10ps

module tb_top import lrc_pkg::*; ;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic linkClk = 1'b0;
    logic cpuWr = 1'b0;
    logic cpuRd = 1'b0;
    logic [7:0] cpuAddr = 8'h00;
    logic [7:0] cpuWrData = 8'h00;
    logic [7:0] cpuRdData;
    logic cpuRdAck;
    lrc_chvec_t pIn = '0;
    lrc_chvec_t nIn = '0;
    lrc_chvec_t dIn = '0;
    lrc_chvec_t aIn = '0;
    lrc_chvec_t rClk, rPos, rNeg, los, eq;
    logic eSel = 1'b0;
    int bad;
    logic [1:0] seen;
    int errCount = 0;
    int numChecks = 0;
    // {e3, rc[5:0], digital, analog, expected loss}
    localparam logic [9:0] LOSS_TC [8] = '{10'h00D, 10'h10C, 10'h10B, 10'h08A,
        10'h18E, 10'h38F, 10'h01E, 10'h008};

    initial forever #50 ref_clk = ~ref_clk;
    initial begin
        #3;
        forever #6 linkClk = ~linkClk;
    end

    lrc_top dut (.ref_clk(ref_clk), .reset(reset), .cpuAddr(cpuAddr),
        .cpuWrData(cpuWrData), .cpuWr(cpuWr), .cpuRd(cpuRd), .cpuRdData(cpuRdData),
        .cpuRdAck(cpuRdAck), .recLinkClk({12{linkClk}}), .rxPosIn(pIn), .rxNegIn(nIn),
        .digital_signal_loss_detector(dIn), .analog_signal_loss_detector(aIn),
        .recovered_clock_output(rClk), .recovered_positive_rail_out(rPos),
        .recovered_negative_rail_out(rNeg), .lossDeclared(los), .eqEnable(eq));

    lrc_framer_model fr (.rclk(rClk[0]), .pos(rPos[0]), .neg(rNeg[0]),
        .edgeSel(eSel), .badLaunch(bad), .held(seen));

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
        numChecks++;
        if (got !== exp) begin
            errCount++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk8

    task automatic chk12(input lrc_chvec_t got, input lrc_chvec_t exp, input string m);
        numChecks++;
        if (got !== exp) begin
            errCount++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk12

    function automatic logic [7:0] adr(input lrc_idx_t c, input logic [3:0] lo);
        return {(c < 4'h6) ? c : c + 4'h2, lo};
    endfunction : adr

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cpuAddr = a;
        cpuWrData = d;
        cpuWr = 1'b1;
        @(negedge ref_clk);
        cpuWr = 1'b0;
        // idle edge, so back-to-back calls never retoggle the strobe in one step
        @(negedge ref_clk);
    endtask : wr

    // answer stands one cycle only, so look at it in that cycle
    task automatic rdChk(input logic [7:0] a, input logic [7:0] exp, input string m);
        cpuAddr = a;
        cpuRd = 1'b1;
        @(negedge ref_clk);
        cpuRd = 1'b0;
        chk8({7'h00, cpuRdAck}, 8'h01, "read ack");
        chk8(cpuRdData, exp, m);
        @(negedge ref_clk);
    endtask : rdChk

    task automatic tRegs;
        lrc_idx_t c;
        rdChk(8'h05, 8'h00, "rc reset");
        chk12(eq, 12'h000, "eq reset");
        for (int i = 0; i < 12; i++) begin
            c = 4'(i);
            wr(adr(c, 4'h5), {2'h3, c, c[1:0]});
        end
        for (int i = 0; i < 12; i++) begin
            c = 4'(i);
            rdChk(adr(c, 4'h5), {2'h0, c, c[1:0]}, "rc readback");
        end
        chk12(eq, 12'hAAA, "eq per channel");
        rdChk(8'h07, 8'h00, "unmapped low");
        rdChk(8'h65, 8'h00, "unmapped nibble 6");
        rdChk(8'hE5, 8'h00, "unmapped nibble E");
        wr(8'hD6, 8'hFF);
        rdChk(8'hD6, 8'h3F, "cc readback");
        wr(8'hD6, 8'h00);
        for (int i = 0; i < 12; i++) begin
            wr(adr(4'(i), 4'h5), 8'h01);
        end
        chk12(eq, 12'hFFF, "eq all on");
    endtask : tRegs

    // same case on channels 0 and 11; latency bound well under 10 cycles
    task automatic tLoss;
        logic [9:0] t;
        for (int i = 0; i < 8; i++) begin
            t = LOSS_TC[i];
            wr(8'h06, {5'h00, t[9], 2'h0});
            wr(8'hD6, {5'h00, t[9], 2'h0});
            wr(8'h05, {2'h0, t[8:3]});
            wr(8'hD5, {2'h0, t[8:3]});
            dIn = {t[2], 10'h000, t[2]};
            aIn = {t[1], 10'h000, t[1]};
            repeat (10) @(negedge ref_clk);
            chk12(los, {t[0], 10'h000, t[0]}, "loss table");
        end
    endtask : tLoss

    task automatic tMute;
        wr(8'h05, 8'h05);
        pIn[0] = 1'b1;
        nIn[0] = 1'b1;
        dIn[0] = 1'b1;
        repeat (10) @(negedge ref_clk);
        chk12(los, 12'h001, "mute loss");
        chk8({6'h00, rPos[0], rNeg[0]}, 8'h00, "muted rails");
        wr(8'h05, 8'h01);
        repeat (10) @(negedge ref_clk);
        chk8({6'h00, rPos[0], rNeg[0]}, 8'h03, "unmuted rails");
        wr(8'h05, 8'h05);
        dIn[0] = 1'b0;
        repeat (10) @(negedge ref_clk);
        chk8({6'h00, rPos[0], rNeg[0]}, 8'h03, "loss cleared");
    endtask : tMute

    task automatic tEdge;
        int b;
        for (int s = 0; s < 2; s++) begin
            eSel = s[0];
            wr(8'h05, {4'h0, s[0], 3'h1});
            repeat (5) @(negedge ref_clk);
            b = bad;
            repeat (20) begin
                {pIn[0], nIn[0]} = {pIn[0], nIn[0]} + 2'h1;
                @(negedge ref_clk);
            end
            repeat (2) @(negedge ref_clk);
            chk8(8'(bad - b), 8'h00, "off-edge launches");
            chk8({6'h00, seen}, {6'h00, pIn[0], nIn[0]}, "framer data");
        end
    endtask : tEdge

    task automatic endOfTest;
        $display("checks %0d errors %0d", numChecks, errCount);
        if (errCount == 0 && numChecks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : endOfTest

    initial begin
        repeat (10) @(negedge ref_clk);
        reset = 1'b0;
        // link side leaves reset a little later
        @(negedge ref_clk);
        tRegs();
        tLoss();
        tMute();
        tEdge();
        endOfTest();
    end
endmodule : tb_top

/* core/lrc_consts.svh */
/*
 Constants for the receive line control block: address layout,
 field positions and reset values. Assumes 8-bit registers.
*/
`ifndef LRC_CONSTS_SVH
`define LRC_CONSTS_SVH

`define LRC_NCH 12
`define LRC_CTL_W 6
`define LRC_LOW_GRP_LAST 4'h5
`define LRC_HIGH_GRP_FIRST 4'h8
`define LRC_HIGH_GRP_LAST 4'hD
`define LRC_HIGH_GRP_SHIFT 4'h2
`define LRC_RC_LOW 4'h5
`define LRC_CC_LOW 4'h6
`define LRC_RC_DIG_DIS 5
`define LRC_RC_ANA_DIS 4
`define LRC_RC_EDGE 3
`define LRC_RC_MUTE 2
`define LRC_RC_MON 1
`define LRC_RC_EQ 0
`define LRC_CC_E3 2
`define LRC_RC_RESET 6'h00
`define LRC_CC_RESET 6'h00
`define LRC_RSV_BITS 2'h0
`define LRC_RD_IDLE 8'h00

`endif

/* core/lrc_pkg.sv */
/*
 Types shared by the receive line control block.
 Assumes lrc_consts.svh is on the include path.
*/
`include "lrc_consts.svh"

package lrc_pkg;
    typedef logic [`LRC_CTL_W-1:0] lrc_ctl_t;
    typedef logic [3:0] lrc_idx_t;
    typedef logic [`LRC_NCH-1:0] lrc_chvec_t;
endpackage : lrc_pkg

/* core/lrc_rx_chan.sv */
/*
 One receive channel on its recovered-clock domain: control and pin
 synchronisers, loss declaration, muting and launch-edge selection.
 Assumes linkClk runs at twice the bit rate; reset comes from ref_clk.
*/
`timescale 1ns/10ps
`include "lrc_consts.svh"

module lrc_rx_chan import lrc_pkg::*; (
    input wire logic linkClk,
    input wire logic reset,
    input wire logic edgeSel,
    input wire logic muteEn,
    input wire logic monitorEn,
    input wire logic digLossDis,
    input wire logic anaLossDis,
    input wire logic e3Mode,
    input wire logic posIn,
    input wire logic negIn,
    input wire logic digLossIn,
    input wire logic anaLossIn,
    output logic clkOut,
    output logic posOut,
    output logic negOut,
    output logic losOut
);
    // quasi-static control bits, so a per-bit two-flop sync is enough
    lrc_ctl_t ctlS1_r, ctlS2_r;
    logic [3:0] pinS1_r, pinS2_r;
    logic rstS1_r, rstS2_r;
    logic clkOut_r, posOut_r, negOut_r, los_r;
    logic clkOut_nxt, posOut_nxt, negOut_nxt, los_nxt;
    logic edgeS, muteS, monS, digLossDisS, anaLossDisS, e3S;
    logic posS, negS, digLossS, anaLossS, launch;

    always_ff @(posedge linkClk) begin
        rstS1_r <= reset;
        rstS2_r <= rstS1_r;
        ctlS1_r <= {e3Mode, digLossDis, anaLossDis, edgeSel, muteEn, monitorEn};
        ctlS2_r <= ctlS1_r;
        pinS1_r <= {posIn, negIn, digLossIn, anaLossIn};
        pinS2_r <= pinS1_r;
    end

    assign {e3S, digLossDisS, anaLossDisS, edgeS, muteS, monS} = ctlS2_r;
    assign {posS, negS, digLossS, anaLossS} = pinS2_r;
    assign launch = (clkOut_r == edgeS);

    always_comb begin
        clkOut_nxt = ~clkOut_r;
        // disable bits only count outside E3
        los_nxt = ~monS & ((digLossS & ~(digLossDisS & ~e3S))
            | (anaLossS & ~(anaLossDisS & ~e3S)));
        posOut_nxt = posOut_r;
        negOut_nxt = negOut_r;
        if (los_nxt && muteS) begin
            // mute at once, not at the next launch edge
            posOut_nxt = 1'b0;
            negOut_nxt = 1'b0;
        end else if (launch) begin
            posOut_nxt = posS;
            negOut_nxt = negS;
        end
    end

    always_ff @(posedge linkClk) begin
        if (rstS2_r) begin
            clkOut_r <= 1'b0;
            posOut_r <= 1'b0;
            negOut_r <= 1'b0;
            los_r <= 1'b0;
        end else begin
            clkOut_r <= clkOut_nxt;
            posOut_r <= posOut_nxt;
            negOut_r <= negOut_nxt;
            los_r <= los_nxt;
        end
    end

    assign clkOut = clkOut_r;
    assign posOut = posOut_r;
    assign negOut = negOut_r;
    assign losOut = los_r;

    property p_rise_launch;
        @(posedge linkClk) disable iff (rstS2_r)
        (!edgeS && !clkOut_r && !(los_nxt && muteS)) |=> (clkOut_r && posOut_r == $past(posS));
    endproperty
    a_rise_launch: assert property (p_rise_launch) else $error("rising launch wrong");

    property p_fall_launch;
        @(posedge linkClk) disable iff (rstS2_r)
        (edgeS && clkOut_r && !(los_nxt && muteS)) |=> (!clkOut_r && negOut_r == $past(negS));
    endproperty
    a_fall_launch: assert property (p_fall_launch) else $error("falling launch wrong");

    property p_mute;
        @(posedge linkClk) disable iff (rstS2_r)
        (los_nxt && muteS) |=> (!posOut_r && !negOut_r && los_r);
    endproperty
    a_mute: assert property (p_mute) else $error("data not muted on loss");

    property p_pass;
        @(posedge linkClk) disable iff (rstS2_r)
        (!muteS && los_nxt && launch) |=> (posOut_r == $past(posS));
    endproperty
    a_pass: assert property (p_pass) else $error("data muted without mute");

    property p_monitor;
        @(posedge linkClk) disable iff (rstS2_r)
        monS[*2] |-> !los_r;
    endproperty
    a_monitor: assert property (p_monitor) else $error("loss in monitor mode");

    property p_normal;
        @(posedge linkClk) disable iff (rstS2_r)
        (!monS && anaLossS && !anaLossDisS) |=> los_r;
    endproperty
    a_normal: assert property (p_normal) else $error("loss missed");

    property p_dig_dis;
        @(posedge linkClk) disable iff (rstS2_r)
        (digLossDisS && !e3S && !anaLossS) |=> !los_r;
    endproperty
    a_dig_dis: assert property (p_dig_dis) else $error("digital detector not off");

    property p_ana_dis;
        @(posedge linkClk) disable iff (rstS2_r)
        (anaLossDisS && !e3S && !digLossS) |=> !los_r;
    endproperty
    a_ana_dis: assert property (p_ana_dis) else $error("analog detector not off");

    property p_e3;
        @(posedge linkClk) disable iff (rstS2_r)
        (e3S && !monS && (digLossS || anaLossS)) |=> los_r;
    endproperty
    a_e3: assert property (p_e3) else $error("disable acted in E3");

    property p_clear;
        @(posedge linkClk) disable iff (rstS2_r)
        (!digLossS && !anaLossS) |=> !los_r;
    endproperty
    a_clear: assert property (p_clear) else $error("loss not cleared");

    c_mute: cover property (@(posedge linkClk) disable iff (rstS2_r)
        muteS && $rose(los_r));
    c_fall: cover property (@(posedge linkClk) disable iff (rstS2_r)
        edgeS && $fell(clkOut_r) && posOut_r);
endmodule : lrc_rx_chan

/* core/lrc_top.sv */
/*
 Receive line control for twelve channels: per-channel receive and
 channel control registers on the parallel processor port, plus the
 receive paths they steer. Assumes the processor port is synchronous
 to ref_clk and each recovered clock runs at twice the bit rate.
*/
`timescale 1ns/10ps
`include "lrc_consts.svh"

module lrc_top import lrc_pkg::*; (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [7:0] cpuAddr,
    input wire logic [7:0] cpuWrData,
    input wire logic cpuWr,
    input wire logic cpuRd,
    output logic [7:0] cpuRdData,
    output logic cpuRdAck,
    input wire lrc_chvec_t recLinkClk,
    input wire lrc_chvec_t rxPosIn,
    input wire lrc_chvec_t rxNegIn,
    input wire lrc_chvec_t digital_signal_loss_detector,
    input wire lrc_chvec_t analog_signal_loss_detector,
    output lrc_chvec_t recovered_clock_output,
    output lrc_chvec_t recovered_positive_rail_out,
    output lrc_chvec_t recovered_negative_rail_out,
    output lrc_chvec_t lossDeclared,
    output lrc_chvec_t eqEnable
);
    lrc_ctl_t [`LRC_NCH-1:0] rc_r, rc_nxt;
    lrc_ctl_t [`LRC_NCH-1:0] cc_r, cc_nxt;
    logic [7:0] rdData_r, rdData_nxt;
    logic rdAck_r, rdAck_nxt;
    lrc_chvec_t eq_r, eq_nxt;
    lrc_chvec_t lossS1_r, lossS2_r;
    lrc_chvec_t losLink;
    logic [4:0] dec;
    logic decValid, rcHit, ccHit;
    lrc_idx_t decIdx;

    // channel nibbles 0-5 map to 0-5, 8-D map to 6-11; 6,7,E,F unmapped
    function automatic logic [4:0] chanDecode(input logic [3:0] hi);
        logic [4:0] res;
        res = 5'h00;
        if (hi <= `LRC_LOW_GRP_LAST) begin
            res = {1'b1, hi};
        end else if (hi >= `LRC_HIGH_GRP_FIRST && hi <= `LRC_HIGH_GRP_LAST) begin
            res = {1'b1, hi - `LRC_HIGH_GRP_SHIFT};
        end
        return res;
    endfunction : chanDecode

    assign dec = chanDecode(cpuAddr[7:4]);
    assign decValid = dec[4];
    assign decIdx = dec[3:0];
    assign rcHit = decValid && (cpuAddr[3:0] == `LRC_RC_LOW);
    assign ccHit = decValid && (cpuAddr[3:0] == `LRC_CC_LOW);

    always_comb begin
        rc_nxt = rc_r;
        cc_nxt = cc_r;
        rdData_nxt = `LRC_RD_IDLE;
        rdAck_nxt = cpuRd;
        if (cpuWr && rcHit) begin
            rc_nxt[decIdx] = cpuWrData[`LRC_CTL_W-1:0];
        end
        if (cpuWr && ccHit) begin
            cc_nxt[decIdx] = cpuWrData[`LRC_CTL_W-1:0];
        end
        // a read in the write cycle returns the old value
        if (cpuRd && rcHit) begin
            rdData_nxt = {`LRC_RSV_BITS, rc_r[decIdx]};
        end else if (cpuRd && ccHit) begin
            rdData_nxt = {`LRC_RSV_BITS, cc_r[decIdx]};
        end
        for (int i = 0; i < `LRC_NCH; i++) begin
            eq_nxt[i] = rc_nxt[i][`LRC_RC_EQ];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rc_r <= {`LRC_NCH{`LRC_RC_RESET}};
            cc_r <= {`LRC_NCH{`LRC_CC_RESET}};
            rdData_r <= `LRC_RD_IDLE;
            rdAck_r <= 1'b0;
            eq_r <= '0;
        end else begin
            rc_r <= rc_nxt;
            cc_r <= cc_nxt;
            rdData_r <= rdData_nxt;
            rdAck_r <= rdAck_nxt;
            eq_r <= eq_nxt;
        end
    end

    // loss status back from each link domain
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            lossS1_r <= '0;
            lossS2_r <= '0;
        end else begin
            lossS1_r <= losLink;
            lossS2_r <= lossS1_r;
        end
    end

    generate
        for (genvar g = 0; g < `LRC_NCH; g++) begin : g_chan
            lrc_rx_chan u_chan (
                .linkClk(recLinkClk[g]),
                .reset(reset),
                .edgeSel(rc_r[g][`LRC_RC_EDGE]),
                .muteEn(rc_r[g][`LRC_RC_MUTE]),
                .monitorEn(rc_r[g][`LRC_RC_MON]),
                .digLossDis(rc_r[g][`LRC_RC_DIG_DIS]),
                .anaLossDis(rc_r[g][`LRC_RC_ANA_DIS]),
                .e3Mode(cc_r[g][`LRC_CC_E3]),
                .posIn(rxPosIn[g]),
                .negIn(rxNegIn[g]),
                .digLossIn(digital_signal_loss_detector[g]),
                .anaLossIn(analog_signal_loss_detector[g]),
                .clkOut(recovered_clock_output[g]),
                .posOut(recovered_positive_rail_out[g]),
                .negOut(recovered_negative_rail_out[g]),
                .losOut(losLink[g])
            );
        end
    endgenerate

    assign cpuRdData = rdData_r;
    assign cpuRdAck = rdAck_r;
    assign lossDeclared = lossS2_r;
    assign eqEnable = eq_r;

    property p_rc_readback;
        @(posedge ref_clk) disable iff (reset)
        (cpuWr && rcHit) ##1 (cpuRd && !cpuWr && cpuAddr == $past(cpuAddr))
        |=> (cpuRdAck && cpuRdData == {`LRC_RSV_BITS, $past(cpuWrData[5:0], 2)});
    endproperty
    a_rc_readback: assert property (p_rc_readback) else $error("rc readback wrong");

    property p_unmapped;
        @(posedge ref_clk) disable iff (reset)
        (cpuRd && !rcHit && !ccHit) |=> (cpuRdAck && cpuRdData == `LRC_RD_IDLE);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

    property p_gap_nibble;
        @(posedge ref_clk) disable iff (reset)
        (cpuAddr[7:4] == 4'h6 || cpuAddr[7:4] == 4'hE) |-> !rcHit;
    endproperty
    a_gap_nibble: assert property (p_gap_nibble) else $error("gap nibble decoded");

    property p_eq_on;
        @(posedge ref_clk) disable iff (reset)
        (cpuWr && rcHit && decIdx == 4'hB) |=> (eqEnable[11] == $past(cpuWrData[0]));
    endproperty
    a_eq_on: assert property (p_eq_on) else $error("equalizer enable wrong");

    property p_eq_hold;
        @(posedge ref_clk) disable iff (reset)
        !(cpuWr && rcHit) |=> $stable(eqEnable);
    endproperty
    a_eq_hold: assert property (p_eq_hold) else $error("equalizer changed");

    property p_ack_follow;
        @(posedge ref_clk) disable iff (reset)
        cpuRd |=> cpuRdAck;
    endproperty
    a_ack_follow: assert property (p_ack_follow) else $error("read not answered");

    property p_ack_only;
        @(posedge ref_clk) disable iff (reset)
        !cpuRd |=> (!cpuRdAck && cpuRdData == `LRC_RD_IDLE);
    endproperty
    a_ack_only: assert property (p_ack_only) else $error("stray read answer");

    property p_rd_rc;
        @(posedge ref_clk) disable iff (reset)
        (cpuRd && rcHit) |=> (cpuRdData == {`LRC_RSV_BITS, $past(rc_r[decIdx])});
    endproperty
    a_rd_rc: assert property (p_rd_rc) else $error("rc read data wrong");

    property p_rd_cc;
        @(posedge ref_clk) disable iff (reset)
        (cpuRd && ccHit) |=> (cpuRdData == {`LRC_RSV_BITS, $past(cc_r[decIdx])});
    endproperty
    a_rd_cc: assert property (p_rd_cc) else $error("cc read data wrong");

    property p_rsv_zero;
        @(posedge ref_clk) disable iff (reset)
        cpuRdAck |-> (cpuRdData[7:6] == `LRC_RSV_BITS);
    endproperty
    a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits set");

    property p_rd_idle;
        @(posedge ref_clk) disable iff (reset)
        !cpuRdAck |-> (cpuRdData == `LRC_RD_IDLE);
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without ack");

    property p_low_grp;
        @(posedge ref_clk) disable iff (reset)
        (cpuAddr[7:4] <= `LRC_LOW_GRP_LAST) |-> (decValid && decIdx == cpuAddr[7:4]);
    endproperty
    a_low_grp: assert property (p_low_grp) else $error("low group decode wrong");

    property p_high_grp;
        @(posedge ref_clk) disable iff (reset)
        (cpuAddr[7:4] >= `LRC_HIGH_GRP_FIRST && cpuAddr[7:4] <= `LRC_HIGH_GRP_LAST)
            |-> (decValid && decIdx == cpuAddr[7:4] - `LRC_HIGH_GRP_SHIFT);
    endproperty
    a_high_grp: assert property (p_high_grp) else $error("high group decode wrong");

    property p_gap_mid;
        @(posedge ref_clk) disable iff (reset)
        (cpuAddr[7:4] > `LRC_LOW_GRP_LAST && cpuAddr[7:4] < `LRC_HIGH_GRP_FIRST) |-> !decValid;
    endproperty
    a_gap_mid: assert property (p_gap_mid) else $error("middle gap decoded");

    property p_gap_top;
        @(posedge ref_clk) disable iff (reset)
        (cpuAddr[7:4] > `LRC_HIGH_GRP_LAST) |-> !decValid;
    endproperty
    a_gap_top: assert property (p_gap_top) else $error("top gap decoded");

    property p_low_nibble;
        @(posedge ref_clk) disable iff (reset)
        (cpuAddr[3:0] != `LRC_RC_LOW) |-> !rcHit;
    endproperty
    a_low_nibble: assert property (p_low_nibble) else $error("rc hit on wrong offset");

    property p_cc_nibble;
        @(posedge ref_clk) disable iff (reset)
        (cpuAddr[3:0] != `LRC_CC_LOW) |-> !ccHit;
    endproperty
    a_cc_nibble: assert property (p_cc_nibble) else $error("cc hit on wrong offset");

    property p_unmapped_wr;
        @(posedge ref_clk) disable iff (reset)
        (cpuWr && !rcHit && !ccHit) |=> ($stable(rc_r) && $stable(cc_r));
    endproperty
    a_unmapped_wr: assert property (p_unmapped_wr) else $error("unmapped write landed");

    // one copy per channel keeps each lane index a constant
    generate
        for (genvar k = 0; k < `LRC_NCH; k++) begin : g_chk
            property p_rc_lane;
                @(posedge ref_clk) disable iff (reset)
                (cpuWr && rcHit && decIdx == k)
                    |=> (rc_r[k] == $past(cpuWrData[`LRC_CTL_W-1:0]));
            endproperty
            a_rc_lane: assert property (p_rc_lane) else $error("rc lane write lost");

            property p_rc_keep;
                @(posedge ref_clk) disable iff (reset)
                !(cpuWr && rcHit && decIdx == k) |=> $stable(rc_r[k]);
            endproperty
            a_rc_keep: assert property (p_rc_keep) else $error("rc lane changed");

            property p_cc_lane;
                @(posedge ref_clk) disable iff (reset)
                (cpuWr && ccHit && decIdx == k)
                    |=> (cc_r[k] == $past(cpuWrData[`LRC_CTL_W-1:0]));
            endproperty
            a_cc_lane: assert property (p_cc_lane) else $error("cc lane write lost");

            property p_cc_keep;
                @(posedge ref_clk) disable iff (reset)
                !(cpuWr && ccHit && decIdx == k) |=> $stable(cc_r[k]);
            endproperty
            a_cc_keep: assert property (p_cc_keep) else $error("cc lane changed");

            property p_eq_lane;
                @(posedge ref_clk) disable iff (reset)
                (cpuWr && rcHit && decIdx == k)
                    |=> (eqEnable[k] == $past(cpuWrData[`LRC_RC_EQ]));
            endproperty
            a_eq_lane: assert property (p_eq_lane) else $error("equalizer lane wrong");

            property p_eq_copy;
                @(posedge ref_clk) disable iff (reset)
                eqEnable[k] == rc_r[k][`LRC_RC_EQ];
            endproperty
            a_eq_copy: assert property (p_eq_copy) else $error("equalizer copy wrong");

            property p_loss_sync;
                @(posedge ref_clk) disable iff (reset)
                lossDeclared[k] == $past(losLink[k], 2);
            endproperty
            a_loss_sync: assert property (p_loss_sync) else $error("loss status lost");
        end
    endgenerate

    c_readback: cover property (p_rc_readback);
    c_unmapped_rd: cover property (@(posedge ref_clk) disable iff (reset)
        cpuRd && !rcHit && !ccHit);
    c_high_grp: cover property (@(posedge ref_clk) disable iff (reset)
        cpuWr && rcHit && cpuAddr[7:4] == 4'hD);
endmodule : lrc_top
